// file: bench/scg_sink.sv
// Downstream consumer model: queues every accepted word.
// Assumes mode 0 prompt, 1 every other cycle, 2 halted.
`timescale 1ns/1ps
`default_nettype none
module scg_sink (
  input wire logic mclk,
  input wire logic [9:0] data,
  input wire logic valid,
  input wire logic [1:0] mode,
  output logic ready
);
  logic [9:0] q[$];
  initial ready = 1'b1;
  always @(posedge mclk) begin
    if (valid && ready) q.push_back(data);
    ready <= (mode == 2'd0) || (mode == 2'd1 && !ready);
  end
endmodule : scg_sink
`default_nettype wire

// file: bench/tb_sdi_checkfield_generator.sv
// Bench for the checkfield generator with sink model.
// Assumes the frame parity starts even after reset.
`timescale 1ns/1ps
`default_nettype none
module tb_sdi_checkfield_generator;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  scg_pkg::scg_fmt_t fmt = scg_pkg::SCG_FMT_1125I;
  logic swap_pairs = 1'b0;
  logic enable = 1'b1;
  logic [9:0] in_data = 10'h000;
  logic in_active = 1'b0;
  logic [10:0] in_line = 11'h000;
  logic in_frame_start = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready, out_valid, out_ready, out_frame_odd;
  logic [9:0] out_data;
  logic [1:0] mode = 2'h0;
  logic [10:0] first [4] = '{11'd41, 11'd45, 11'd21, 11'd42};
  logic [10:0] sw [4] = '{11'd299, 11'd333, 11'd291, 11'd582};
  logic [10:0] sw2 [3] = '{11'd861, 11'd958, 11'd854};
  int failures = 0;
  int checked = 0;
  always #12.5 mclk = ~mclk;
  scg_checkfield scg_checkfield_i (.mclk(mclk), .arst_n(arst_n), .fmt(fmt), .swap_pairs(swap_pairs),
    .enable(enable), .in_data(in_data), .in_active(in_active), .in_line(in_line),
    .in_frame_start(in_frame_start), .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_frame_odd(out_frame_odd));
  scg_sink scg_sink_i (.mclk(mclk), .data(out_data), .valid(out_valid), .mode(mode), .ready(out_ready));
  task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task send(input logic [9:0] d, input logic a, input logic [10:0] ln, input logic fs);
    in_data <= d;
    in_active <= a;
    in_line <= ln;
    in_frame_start <= fs;
    in_valid <= 1'b1;
    @(posedge mclk iff in_ready);
  endtask : send
  task pull(input string nm, input logic [9:0] e);
    int n;
    n = 0;
    while (scg_sink_i.q.size() == 0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (scg_sink_i.q.size() == 0) chk(nm, e, ~e);
    else chk(nm, e, scg_sink_i.q.pop_front());
  endtask : pull
  // Blank word, then one group of four active words
  task line4(input logic [10:0] ln, input logic fs, input logic [9:0] c, input logic [9:0] y,
             input logic [9:0] y1);
    send(10'h3FF, 1'b0, ln, fs);
    send(10'h040, 1'b1, ln, 1'b0);
    send(10'h040, 1'b1, ln, 1'b0);
    send(10'h040, 1'b1, ln, 1'b0);
    send(10'h040, 1'b1, ln, 1'b0);
    in_valid <= 1'b0;
    pull("blank", 10'h3FF);
    pull("cb", c);
    pull("y0", y1);
    pull("cr", c);
    pull("y1", y);
  endtask : line4
  task t_formats;
    for (int k = 0; k < 4; k++) begin
      fmt <= scg_pkg::scg_fmt_t'(k);
      mode <= (k == 2) ? 2'd1 : 2'd0;
      line4(first[k], 1'b1, 10'h300, 10'h198, (k % 2 == 0) ? 10'h190 : 10'h198);
      chk("parity", {9'h0, k % 2 == 0}, {9'h0, out_frame_odd});
      line4(sw[k], 1'b0, 10'h300, 10'h198, 10'h198);
      line4(sw[k] + 11'd1, 1'b0, 10'h200, 10'h110, 10'h110);
      if (k < 3) begin
        line4(sw2[k], 1'b0, 10'h300, 10'h198, 10'h198);
        line4(sw2[k] + 11'd1, 1'b0, 10'h200, 10'h110, 10'h110);
      end
    end
  endtask : t_formats
  task t_swap;
    swap_pairs <= 1'b1;
    line4(11'd42, 1'b1, 10'h198, 10'h300, 10'h200);
    line4(11'd583, 1'b0, 10'h110, 10'h200, 10'h200);
    swap_pairs <= 1'b0;
  endtask : t_swap
  task t_pass;
    line4(11'd10, 1'b1, 10'h040, 10'h040, 10'h040);
    enable <= 1'b0;
    line4(11'd42, 1'b0, 10'h040, 10'h040, 10'h040);
    enable <= 1'b1;
  endtask : t_pass
  // Halted sink fills the buffer until it refuses
  task t_fill;
    int n;
    n = 0;
    mode <= 2'd2;
    send(10'h3FF, 1'b0, 11'd5, 1'b0);
    repeat (40) begin
      @(negedge mclk);
      if (in_ready) n++;
    end
    @(posedge mclk);
    in_valid <= 1'b0;
    chk("refused", 10'h000, {9'h0, in_ready});
    chk("depth", 10'h001, {9'h0, n == scg_pkg::FIFO_DEPTH});
    mode <= 2'd0;
    repeat (n + 1) pull("drain", 10'h3FF);
    repeat (20) @(posedge mclk);
    chk("empty", 10'h000, 10'(scg_sink_i.q.size()));
  endtask : t_fill
  task stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    repeat (3) @(posedge mclk);
    chk("reset valid", 10'h000, {9'h0, out_valid});
    arst_n <= 1'b1;
    @(posedge mclk);
    t_formats;
    t_swap;
    t_pass;
    t_fill;
    stop_test;
  end
  initial begin
    #(20000 * 25);
    failures++;
    stop_test;
  end
endmodule : tb_sdi_checkfield_generator
`default_nettype wire

// file: rtl/scg_checkfield.sv
// Checkfield generator: replaces active samples of an incoming raster
// with equalizer and PLL stress words; everything else passes unchanged.
// Assumes upstream marks active words and gives line number and frame start.
`timescale 1ns/1ps
`default_nettype none
module scg_checkfield #(
  parameter int W = scg_pkg::WORD_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire scg_pkg::scg_fmt_t fmt,
  input wire logic swap_pairs,
  input wire logic enable,
  input wire logic [W-1:0] in_data,
  input wire logic in_active,
  input wire logic [scg_pkg::LINE_W-1:0] in_line,
  input wire logic in_frame_start,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_frame_odd
);
  logic [scg_pkg::SAMP_W-1:0] samp_r;
  logic odd_frame_r;
  logic [W-1:0] word_nxt;
  logic fire;
  logic in_field1;
  logic in_field2;
  logic eq_zone;
  logic first_line;
  logic [W-1:0] out_data_r;
  logic out_valid_r;
  localparam int OW = $clog2(scg_pkg::FIFO_DEPTH) + 1;
  logic [OW-1:0] occ_r;
  logic [OW-1:0] occ_nxt;
  logic in_ready_r;
  logic drain;
  scg_stream_if #(.W(W)) fin();
  scg_stream_if #(.W(W)) fout();

  function automatic logic in_range(input logic [10:0] l, input logic [10:0] lo, input logic [10:0] hi);
    in_range = (l >= lo) && (l <= hi);
  endfunction : in_range

  assign fire = in_valid && fin.ready;
  assign in_ready = in_ready_r;

  always_comb begin
    in_field1 = in_range(in_line, scg_pkg::F1_FIRST[fmt], scg_pkg::F1_LAST[fmt]);
    in_field2 = (fmt != scg_pkg::SCG_FMT_1080P) &&
                in_range(in_line, scg_pkg::F2_FIRST[fmt], scg_pkg::F2_LAST[fmt]);
    // fixed switch, PLL on the next line
    eq_zone = (in_field1 && in_line <= scg_pkg::EQ_END_F1[fmt]) ||
              (in_field2 && in_line <= scg_pkg::EQ_END_F2[fmt]);
    first_line = in_line == scg_pkg::F1_FIRST[fmt];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      samp_r <= '0;
    end else if (fire) begin
      if (!in_active || samp_r == scg_pkg::LAST_SAMPLE) begin
        samp_r <= '0;
      end else begin
        samp_r <= samp_r + 12'h001;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      odd_frame_r <= 1'b0;
    end else if (fire && in_frame_start) begin
      odd_frame_r <= ~odd_frame_r;
    end
  end

  always_comb begin
    word_nxt = in_data;
    if (enable && in_active && (in_field1 || in_field2)) begin
      if (eq_zone) begin
        word_nxt = (samp_r[0] ^ swap_pairs) ? scg_pkg::EQ_LUMA : scg_pkg::EQ_CHROMA;
      end else begin
        word_nxt = (samp_r[0] ^ swap_pairs) ? scg_pkg::PLL_LUMA : scg_pkg::PLL_CHROMA;
      end
      if (odd_frame_r && first_line && samp_r == scg_pkg::POL_SAMPLE) begin
        word_nxt = swap_pairs ? scg_pkg::POL_WORD_SWAP : scg_pkg::POL_WORD;
      end
    end
  end

  assign fin.data = word_nxt;
  assign fin.valid = in_valid;

  scg_fifo #(.W(W), .DEPTH(scg_pkg::FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_s(fin),
    .out_s(fout)
  );

  // Registered output stage, skid-free: loads only when empty or drained
  assign fout.ready = !out_valid_r || out_ready;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_data_r <= '0;
      out_valid_r <= 1'b0;
    end else if (fout.ready) begin
      out_data_r <= fout.data;
      out_valid_r <= fout.valid;
    end
  end
  assign out_data = out_data_r;
  assign out_valid = out_valid_r;
  assign out_frame_odd = odd_frame_r;

  // Mirror of the buffer fill, so in_ready leaves a flip-flop
  assign drain = fout.valid && fout.ready;
  always_comb begin
    occ_nxt = occ_r + OW'(fire) - OW'(drain);
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      occ_r <= '0;
      in_ready_r <= 1'b1;
    end else begin
      occ_r <= occ_nxt;
      in_ready_r <= occ_nxt != OW'(scg_pkg::FIFO_DEPTH);
    end
  end

  eq_words_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && eq_zone && !swap_pairs && samp_r[0] && !(odd_frame_r && first_line)
    |-> fin.data == 10'h198)
    else $error("equalizer luma wrong");
  eq_chroma_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && eq_zone && !swap_pairs && !samp_r[0]
    |-> fin.data == 10'h300)
    else $error("equalizer chroma wrong");
  pll_words_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && (in_field1 || in_field2) && !eq_zone && !swap_pairs && !samp_r[0]
    |-> fin.data == 10'h200)
    else $error("pll chroma wrong");
  pll_luma_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && (in_field1 || in_field2) && !eq_zone && !swap_pairs && samp_r[0]
    |-> fin.data == 10'h110)
    else $error("pll luma wrong");

  samp_wrap_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && in_active && samp_r == 12'hEFF
    |=> samp_r == 12'h000)
    else $error("sample index wrap");
  samp_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && in_active && samp_r != 12'hEFF
    |=> samp_r == $past(samp_r) + 12'h001)
    else $error("sample index step");
  samp_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && !in_active
    |=> samp_r == 12'h000)
    else $error("sample index clear");

  // field windows add up to the height
  height_a: assert property (@(posedge mclk) disable iff (!arst_n)
    scg_pkg::ACTIVE_LINES[fmt] == scg_pkg::F1_LAST[fmt] - scg_pkg::F1_FIRST[fmt] + 11'h001 +
    ((fmt == scg_pkg::SCG_FMT_1080P) ? 11'h000 : scg_pkg::F2_LAST[fmt] - scg_pkg::F2_FIRST[fmt] + 11'h001))
    else $error("height table");
  eq_start_a: assert property (@(posedge mclk) disable iff (!arst_n)
    in_line == scg_pkg::F1_FIRST[fmt] || (fmt != scg_pkg::SCG_FMT_1080P && in_line == scg_pkg::F2_FIRST[fmt])
    |-> eq_zone)
    else $error("equalizer start line");
  pll_end_a: assert property (@(posedge mclk) disable iff (!arst_n)
    in_line == scg_pkg::F1_LAST[fmt] || (fmt != scg_pkg::SCG_FMT_1080P && in_line == scg_pkg::F2_LAST[fmt])
    |-> (in_field1 || in_field2) && !eq_zone)
    else $error("pll last line");
  fix_switch_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fmt != scg_pkg::SCG_FMT_1080P
    |-> scg_pkg::EQ_END_F1[fmt] - scg_pkg::F1_FIRST[fmt] == scg_pkg::EQ_END_F2[fmt] - scg_pkg::F2_FIRST[fmt])
    else $error("switch offset differs");

  win_1125_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fmt == scg_pkg::SCG_FMT_1125I |-> in_range(scg_pkg::EQ_END_F1[fmt], 11'h127, 11'h12E) &&
    in_range(scg_pkg::EQ_END_F2[fmt], 11'h35A, 11'h361) && scg_pkg::F1_FIRST[fmt] == 11'h029)
    else $error("1125i switch range");
  win_1250_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fmt == scg_pkg::SCG_FMT_1250I |-> in_range(scg_pkg::EQ_END_F1[fmt], 11'h149, 11'h14F) &&
    in_range(scg_pkg::EQ_END_F2[fmt], 11'h3BA, 11'h3C0) && scg_pkg::F1_FIRST[fmt] == 11'h02D)
    else $error("1250i switch range");
  win_1080i_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fmt == scg_pkg::SCG_FMT_1080I |-> in_range(scg_pkg::EQ_END_F1[fmt], 11'h11F, 11'h125) &&
    in_range(scg_pkg::EQ_END_F2[fmt], 11'h352, 11'h358) && scg_pkg::F1_FIRST[fmt] == 11'h015)
    else $error("1080i switch range");
  win_1080p_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fmt == scg_pkg::SCG_FMT_1080P |-> in_range(scg_pkg::EQ_END_F1[fmt], 11'h242, 11'h249) &&
    scg_pkg::F1_FIRST[fmt] == 11'h02A && scg_pkg::F1_LAST[fmt] == 11'h461)
    else $error("1080p switch range");

  eq_last_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (in_field1 && in_line == scg_pkg::EQ_END_F1[fmt]) || (in_field2 && in_line == scg_pkg::EQ_END_F2[fmt])
    |-> eq_zone)
    else $error("switch line not equalizer");
  switch_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (in_field1 && in_line == scg_pkg::EQ_END_F1[fmt] + 11'h001) ||
    (in_field2 && in_line == scg_pkg::EQ_END_F2[fmt] + 11'h001) |-> !eq_zone)
    else $error("pll start line");

  pol_word_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && odd_frame_r && first_line && samp_r == 12'h001 && !swap_pairs
    |-> fin.data == 10'h190)
    else $error("polarity word");
  pol_skip_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && !odd_frame_r && first_line && samp_r == 12'h001 && !swap_pairs
    |-> fin.data == 10'h198)
    else $error("polarity word in wrong frame");
  pol_swap_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && odd_frame_r && first_line && samp_r == 12'h001 && swap_pairs
    |-> fin.data == 10'h200)
    else $error("swapped polarity word");
  eq_swap_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && eq_zone && swap_pairs && !samp_r[0]
    |-> fin.data == 10'h198)
    else $error("swapped equalizer pair");
  pll_swap_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && (in_field1 || in_field2) && !eq_zone && swap_pairs && samp_r[0]
    |-> fin.data == 10'h200)
    else $error("swapped pll pair");
  pol_bit_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && enable && in_active && odd_frame_r && first_line && samp_r == 12'h001
    |-> $countones(fin.data ^ (swap_pairs ? 10'h300 : 10'h198)) == 1)
    else $error("polarity word bit change");
  frame_tog_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && in_frame_start
    |=> odd_frame_r != $past(odd_frame_r))
    else $error("frame toggle");

  pass_blank_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && !in_active
    |-> fin.data == in_data)
    else $error("blanking altered");
  pass_off_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && !enable
    |-> fin.data == in_data)
    else $error("disabled data altered");
  pass_out_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fire && in_active && !in_field1 && !in_field2
    |-> fin.data == in_data)
    else $error("outside field altered");
  // no word lost at the input
  ready_mirror_a: assert property (@(posedge mclk) disable iff (!arst_n)
    1'b1
    |-> in_ready == fin.ready)
    else $error("ready mirror differs");
  // no word lost at the output
  out_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    out_valid && !out_ready
    |=> out_valid && $stable(out_data))
    else $error("output not held");
endmodule : scg_checkfield
`default_nettype wire

// file: rtl/scg_fifo.sv
// Synchronous FIFO with valid/ready both sides.
// Assumes single clock domain.
`timescale 1ns/1ps
`default_nettype none
module scg_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  scg_stream_if.snk in_s,
  scg_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic wr;
  logic rd;
  // Full at DEPTH words; count is one bit wider than the pointers
  assign in_s.ready = cnt_r != (AW+1)'(DEPTH);
  assign out_s.valid = cnt_r != '0;
  assign out_s.data = mem_r[rp_r];
  assign wr = in_s.valid && in_s.ready;
  assign rd = out_s.valid && out_s.ready;
  always_ff @(posedge mclk) begin
    if (wr) begin
      mem_r[wp_r] <= in_s.data;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) begin
        wp_r <= wp_r + AW'(1);
      end
      if (rd) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule : scg_fifo
`default_nettype wire

// file: rtl/scg_pkg.sv
// Package for the checkfield generator: codes, line tables, formats.
// Assumes 10-bit 4:2:2 words, 8.2 fixed point.
`default_nettype none
package scg_pkg;
  localparam int WORD_W = 10;
  localparam int LINE_W = 11;
  localparam int SAMP_W = 12;
  localparam logic [9:0] EQ_CHROMA = 10'h300;
  localparam logic [9:0] EQ_LUMA = 10'h198;
  localparam logic [9:0] PLL_CHROMA = 10'h200;
  localparam logic [9:0] PLL_LUMA = 10'h110;
  localparam logic [9:0] POL_WORD = 10'h190;
  localparam logic [9:0] POL_WORD_SWAP = 10'h200;
  localparam logic [11:0] ACTIVE_SAMPLES = 12'hF00;
  localparam logic [11:0] LAST_SAMPLE = 12'hEFF;
  localparam logic [11:0] POL_SAMPLE = 12'h001;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {SCG_FMT_1125I, SCG_FMT_1250I, SCG_FMT_1080I, SCG_FMT_1080P} scg_fmt_t;
  localparam logic [10:0] F1_FIRST [4] = '{11'h029, 11'h02D, 11'h015, 11'h02A};
  localparam logic [10:0] F1_LAST [4] = '{11'h22D, 11'h26C, 11'h230, 11'h461};
  localparam logic [10:0] F2_FIRST [4] = '{11'h25B, 11'h29E, 11'h248, 11'h000};
  localparam logic [10:0] F2_LAST [4] = '{11'h460, 11'h4DD, 11'h463, 11'h000};
  localparam logic [10:0] EQ_END_F1 [4] = '{11'h12B, 11'h14D, 11'h123, 11'h246};
  // Field 2 switch sits at the same offset from its first line as field 1
  localparam logic [10:0] EQ_END_F2 [4] = '{11'h35D, 11'h3BE, 11'h356, 11'h000};
  localparam logic [10:0] ACTIVE_LINES [4] = '{11'h40B, 11'h480, 11'h438, 11'h438};
endpackage : scg_pkg
`default_nettype wire

// file: rtl/scg_stream_if.sv
// Interface carrying a valid/ready video word stream between modules.
// Assumes one shared clock.
`timescale 1ns/1ps
`default_nettype none
interface scg_stream_if #(parameter int W = 10);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : scg_stream_if
`default_nettype wire
